// [logic/svd_decoder.sv]
/*
  Vector instruction decoder with AHB-Lite control and interrupt.
  Assumes the issue stage drives instr_valid and instr_word on hclk,
  and a single AHB-Lite master doing single word transfers.
*/
// Behaviour
// [RL1] Detect extension major and FP coprocessor opcodes
// [RL2] FP rs 01011/01111 are whole-vector branches
// [RL3] rs 11xxx are per-element branches B/H/W/D
// [RL4] Minor opcode ranges map to format classes
// [RL5] Minor bits 5..3 of 100 is memory class
// [RL6] Unassigned minors flagged reserved, raise exception
// [RL7] Memory op 1000 load, 1001 store, fmt
// [RL8] Imm5 op in 25..23, fmt in 22..21
// [RL9] Imm5 op 000 is add or compare-equal
// [RL10] Imm5 op 001 subtract, reserved under compare
// [RL11] Imm5 op 010 signed max or less-than
// [RL12] Imm5 op 011 unsigned max or less-than
// [RL13] Imm5 op 100 signed min or less-equal
// [RL14] Imm5 op 101 unsigned min or less-equal
// [RL15] Decode results registered with word, reset clears
`timescale 1ns/1ps
module svd_decoder (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Issue stage request
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  // Decoded result
  output logic dec_valid,
  output logic [31:0] dec_word,
  output svd_pkg::svd_class_e dec_class,
  output svd_pkg::svd_op_e dec_op,
  output logic [1:0] dec_fmt,
  output logic dec_rsvd,
  output logic exc_reserved,
  output logic exc_disabled,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    logic dec_valid;
    logic [31:0] word;
    svd_pkg::svd_dec_s dec;
    logic exc_ri;
    logic exc_dis;
    logic ctrl_en;
    logic [svd_pkg::ST_W-1:0] status;
    logic [svd_pkg::ST_W-1:0] mask;
    logic a_we;
    logic [7:0] a_addr;
    logic [31:0] rdata;
  } svd_state_s;

  svd_state_s st_ff;
  svd_state_s nxt_st;

  function automatic svd_pkg::svd_dec_s svd_decode(input logic [31:0] w);
    svd_pkg::svd_dec_s d;
    logic [2:0] op3;
    logic cmp;
    d.cls = svd_pkg::CLS_NONE;
    d.op = svd_pkg::OP_NONE;
    d.fmt = 2'h0;
    d.rsvd = 1'b0;
    op3 = w[25:23];
    cmp = (w[5:0] == svd_pkg::MINOR_I5_CMP);
    if (w[31:26] == svd_pkg::MAJOR_EXT) begin // [RL1]
      if (w[5:3] == svd_pkg::MINOR_MEM_HI) begin // [RL5]
        d.cls = svd_pkg::CLS_MEM_OFS;
        d.fmt = w[1:0]; // [RL7]
        d.op = (w[5:2] == svd_pkg::MEM_LOAD) ? svd_pkg::OP_VEC_LOAD :
          svd_pkg::OP_VEC_STORE; // [RL7]
      end else begin
        case (w[5:0]) inside // [RL4]
          [6'h00:6'h02]: d.cls = svd_pkg::CLS_IMM8;
          [6'h06:6'h07]: d.cls = svd_pkg::CLS_IMM5;
          [6'h09:6'h0a]: d.cls = svd_pkg::CLS_BIT;
          [6'h0d:6'h15]: d.cls = svd_pkg::CLS_THREE_REG;
          6'h19: d.cls = svd_pkg::CLS_ELEMENT;
          [6'h1a:6'h1c]: d.cls = svd_pkg::CLS_THREE_REG_FLOAT;
          6'h1e: d.cls = svd_pkg::CLS_VEC_TWO_REG;
          default: begin
            d.cls = svd_pkg::CLS_RESERVED; // [RL6]
            d.rsvd = 1'b1; // [RL6]
          end
        endcase
        if (d.cls == svd_pkg::CLS_IMM5) begin
          d.fmt = w[22:21]; // [RL8]
          case (op3) // [RL8]
            3'h0: d.op = cmp ? svd_pkg::OP_CMP_EQ_IMM :
              svd_pkg::OP_ADD_IMM; // [RL9]
            3'h1: begin
              d.op = cmp ? svd_pkg::OP_NONE : svd_pkg::OP_SUB_IMM; // [RL10]
              d.rsvd = cmp; // [RL10]
            end
            3'h2: d.op = cmp ? svd_pkg::OP_S_LT_IMM :
              svd_pkg::OP_S_MAX_IMM; // [RL11]
            3'h3: d.op = cmp ? svd_pkg::OP_U_LT_IMM :
              svd_pkg::OP_U_MAX_IMM; // [RL12]
            3'h4: d.op = cmp ? svd_pkg::OP_S_LE_IMM :
              svd_pkg::OP_S_MIN_IMM; // [RL13]
            3'h5: d.op = cmp ? svd_pkg::OP_U_LE_IMM :
              svd_pkg::OP_U_MIN_IMM; // [RL14]
            3'h6: begin
              // Wider immediate form shares this minor
              d.op = cmp ? svd_pkg::OP_LOAD_IMM : svd_pkg::OP_NONE;
              d.rsvd = !cmp;
            end
            default: d.rsvd = 1'b1;
          endcase
        end
      end
    end else if (w[31:26] == svd_pkg::MAJOR_FP) begin // [RL1]
      d.cls = svd_pkg::CLS_FP;
      if (w[25:21] == svd_pkg::RS_ALL_ZERO) begin
        d.op = svd_pkg::OP_BR_VEC_ALL_ZERO; // [RL2]
      end else if (w[25:21] == svd_pkg::RS_NOT_ZERO) begin
        d.op = svd_pkg::OP_BR_VEC_NOT_ZERO; // [RL2]
      end else if (w[25:24] == svd_pkg::RS_ELEM_HI) begin
        d.fmt = w[22:21]; // [RL3]
        d.op = w[23] ? svd_pkg::OP_BR_NO_ELEM_ZERO :
          svd_pkg::OP_BR_ANY_ELEM_ZERO; // [RL3]
      end
    end
    return d;
  endfunction : svd_decode

  function automatic logic [31:0] svd_read(input svd_state_s s,
                                           input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0;
    if (a == svd_pkg::OFS_CTRL) begin
      r[svd_pkg::CTRL_EN_BIT] = s.ctrl_en;
    end else if (a == svd_pkg::OFS_STATUS) begin
      r[svd_pkg::ST_W-1:0] = s.status;
    end else if (a == svd_pkg::OFS_MASK) begin
      r[svd_pkg::ST_W-1:0] = s.mask;
    end else if (a == svd_pkg::OFS_LAST) begin
      r = s.word;
    end
    return r;
  endfunction : svd_read

  svd_pkg::svd_dec_s cur;
  logic is_ext;
  logic is_branch;
  logic addr_ok;
  logic [svd_pkg::ST_W-1:0] ev;
  logic [svd_pkg::ST_W-1:0] clr;

  always_comb begin
    nxt_st = st_ff;
    cur = svd_decode(instr_word);
    is_ext = (instr_word[31:26] == svd_pkg::MAJOR_EXT);
    is_branch = (cur.op inside {svd_pkg::OP_BR_VEC_ALL_ZERO,
      svd_pkg::OP_BR_VEC_NOT_ZERO, svd_pkg::OP_BR_ANY_ELEM_ZERO,
      svd_pkg::OP_BR_NO_ELEM_ZERO});
    // Valid follows the issue stage every cycle; word and decode load only on valid
    nxt_st.dec_valid = instr_valid; // [RL15]
    if (instr_valid) begin
      nxt_st.word = instr_word; // [RL15]
      nxt_st.dec = cur; // [RL15]
    end
    // Disabled extension wins over reserved so software can lazily enable
    nxt_st.exc_dis = instr_valid && (is_ext || is_branch) &&
      !st_ff.ctrl_en; // [RL6]
    nxt_st.exc_ri = instr_valid && cur.rsvd && st_ff.ctrl_en; // [RL6]
    ev = '0;
    ev[svd_pkg::ST_RSVD_BIT] = nxt_st.exc_ri;
    ev[svd_pkg::ST_DIS_BIT] = nxt_st.exc_dis;
    ev[svd_pkg::ST_BR_BIT] = instr_valid && is_branch;
    // Bus address phase; data is registered a phase early, zero wait
    addr_ok = hsel && htrans[1] && hready;
    nxt_st.a_we = addr_ok && hwrite;
    if (addr_ok) begin
      nxt_st.a_addr = haddr[7:0];
      nxt_st.rdata = svd_read(st_ff, haddr[7:0]);
    end
    clr = '0;
    if (st_ff.a_we) begin
      if (st_ff.a_addr == svd_pkg::OFS_CTRL) begin
        nxt_st.ctrl_en = hwdata[svd_pkg::CTRL_EN_BIT];
      end else if (st_ff.a_addr == svd_pkg::OFS_STATUS) begin
        clr = hwdata[svd_pkg::ST_W-1:0];
      end else if (st_ff.a_addr == svd_pkg::OFS_MASK) begin
        nxt_st.mask = hwdata[svd_pkg::ST_W-1:0];
      end
    end
    // Set beats write-one-to-clear in the same cycle
    nxt_st.status = (st_ff.status & ~clr) | ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
      st_ff.ctrl_en <= svd_pkg::CTRL_EN_RST;
      st_ff.mask <= svd_pkg::MASK_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dec_valid = st_ff.dec_valid;
  assign dec_word = st_ff.word;
  assign dec_class = st_ff.dec.cls;
  assign dec_op = st_ff.dec.op;
  assign dec_fmt = st_ff.dec.fmt;
  assign dec_rsvd = st_ff.dec.rsvd;
  assign exc_reserved = st_ff.exc_ri;
  assign exc_disabled = st_ff.exc_dis;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_ff.rdata;
  assign irq = |(st_ff.status & st_ff.mask);

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_major;
    instr_valid && instr_word[31:26] == svd_pkg::MAJOR_EXT
      |=> dec_class != svd_pkg::CLS_NONE && dec_class != svd_pkg::CLS_FP;
  endproperty
  a_major: assert property (p_major) else $error("major not seen"); // [RL1]

  property p_fp;
    instr_valid && instr_word[31:26] == svd_pkg::MAJOR_FP
      |=> dec_class == svd_pkg::CLS_FP;
  endproperty
  a_fp: assert property (p_fp) else $error("fp class missed"); // [RL1]

  property p_bzv;
    instr_valid && instr_word[31:21] == {svd_pkg::MAJOR_FP, 5'h0b}
      |=> dec_op == svd_pkg::OP_BR_VEC_ALL_ZERO;
  endproperty
  a_bzv: assert property (p_bzv) else $error("vector branch wrong"); // [RL2]

  property p_belem;
    instr_valid && instr_word[31:24] == {svd_pkg::MAJOR_FP, 2'h3}
      |=> dec_fmt == $past(instr_word[22:21]) &&
      (dec_op == svd_pkg::OP_BR_NO_ELEM_ZERO) == $past(instr_word[23]);
  endproperty
  a_belem: assert property (p_belem) else $error("elem branch wrong"); // [RL3]

  property p_mem;
    instr_valid && instr_word[31:26] == svd_pkg::MAJOR_EXT &&
      instr_word[5:3] == 3'h4
      |=> dec_class == svd_pkg::CLS_MEM_OFS && !dec_rsvd &&
      (dec_op == svd_pkg::OP_VEC_STORE) == $past(instr_word[2]);
  endproperty
  a_mem: assert property (p_mem) else $error("memory decode wrong"); // [RL5]

  property p_rsvd;
    instr_valid && instr_word[31:26] == svd_pkg::MAJOR_EXT &&
      instr_word[5] && (instr_word[4] || instr_word[3])
      |=> dec_rsvd ##0 (exc_reserved || exc_disabled);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved missed"); // [RL6]

  property p_add;
    instr_valid && instr_word[31:26] == svd_pkg::MAJOR_EXT &&
      instr_word[25:23] == 3'h0 && instr_word[5:0] == 6'h06
      |=> dec_op == svd_pkg::OP_ADD_IMM && dec_fmt == $past(instr_word[22:21]);
  endproperty
  a_add: assert property (p_add) else $error("add imm wrong"); // [RL9]

  property p_sub;
    instr_valid && instr_word[31:26] == svd_pkg::MAJOR_EXT &&
      instr_word[25:23] == 3'h1 && instr_word[5:0] == 6'h07 |=> dec_rsvd;
  endproperty
  a_sub: assert property (p_sub) else $error("sub cmp not rsvd"); // [RL10]

  property p_ulei;
    instr_valid && instr_word[31:26] == svd_pkg::MAJOR_EXT &&
      instr_word[25:23] == 3'h5 && instr_word[5:0] == 6'h07
      |=> dec_op == svd_pkg::OP_U_LE_IMM;
  endproperty
  a_ulei: assert property (p_ulei) else $error("ule imm wrong"); // [RL14]

  property p_word;
    instr_valid |=> dec_valid && dec_word == $past(instr_word);
  endproperty
  a_word: assert property (p_word) else $error("word not held"); // [RL15]

  property p_irq;
    st_ff.status[svd_pkg::ST_RSVD_BIT] && st_ff.mask[svd_pkg::ST_RSVD_BIT]
      |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");
endmodule : svd_decoder

// [logic/svd_pkg.sv]
/*
  Constants and types shared by the vector opcode decoder.
  Assumes a 32-bit instruction word and a 32-bit AHB-Lite register bus.
*/
package svd_pkg;
  // Major opcode, bits 31..26
  localparam logic [5:0] MAJOR_EXT = 6'h1e;
  localparam logic [5:0] MAJOR_FP = 6'h11;
  // Branch rs values, bits 25..21
  localparam logic [4:0] RS_ALL_ZERO = 5'h0b;
  localparam logic [4:0] RS_NOT_ZERO = 5'h0f;
  localparam logic [1:0] RS_ELEM_HI = 2'h3;
  // Minor opcode groups, bits 5..0
  localparam logic [2:0] MINOR_MEM_HI = 3'h4;
  localparam logic [5:0] MINOR_I5_ADD = 6'h06;
  localparam logic [5:0] MINOR_I5_CMP = 6'h07;
  localparam logic [3:0] MEM_LOAD = 4'h8;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_LAST = 8'h0c;
  // Field positions and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam int ST_RSVD_BIT = 0;
  localparam int ST_DIS_BIT = 1;
  localparam int ST_BR_BIT = 2;
  localparam int ST_W = 3;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [2:0] MASK_RST = 3'h0;

  typedef enum logic [3:0] {
    CLS_NONE, CLS_FP, CLS_IMM8, CLS_IMM5, CLS_BIT, CLS_THREE_REG,
    CLS_ELEMENT, CLS_THREE_REG_FLOAT, CLS_VEC_TWO_REG, CLS_MEM_OFS,
    CLS_RESERVED
  } svd_class_e;

  typedef enum logic [4:0] {
    OP_NONE, OP_BR_VEC_ALL_ZERO, OP_BR_VEC_NOT_ZERO, OP_BR_ANY_ELEM_ZERO,
    OP_BR_NO_ELEM_ZERO, OP_VEC_LOAD, OP_VEC_STORE, OP_ADD_IMM,
    OP_CMP_EQ_IMM, OP_SUB_IMM, OP_S_MAX_IMM, OP_S_LT_IMM, OP_U_MAX_IMM,
    OP_U_LT_IMM, OP_S_MIN_IMM, OP_S_LE_IMM, OP_U_MIN_IMM, OP_U_LE_IMM,
    OP_LOAD_IMM
  } svd_op_e;

  typedef struct packed {
    svd_class_e cls;
    svd_op_e op;
    logic [1:0] fmt;
    logic rsvd;
  } svd_dec_s;
endpackage : svd_pkg

// [sim/svd_issue_model.sv]
/*
  Issue stage model: hands instruction words to the decoder, one a cycle.
  Assumes the bench calls send from one thread and ends with a gap.
*/
`timescale 1ns/1ps
module svd_issue_model (
  // Clock
  input wire logic hclk,
  // Words towards the decoder
  output logic instr_valid,
  output logic [31:0] instr_word
);
  initial begin
    instr_valid = 1'b0;
    instr_word = 32'h0;
  end
  // Gap cycles invert the stale word each cycle; afterwards it holds still
  task automatic send(input logic [31:0] w, input int gap);
    @(posedge hclk);
    instr_valid <= 1'b1;
    instr_word <= w;
    for (int i = 0; i < gap; i++) begin
      @(posedge hclk);
      instr_valid <= 1'b0;
      instr_word <= ~instr_word;
    end
  endtask : send
endmodule : svd_issue_model

// [sim/tb.sv]
/*
  Self-checking bench for the vector opcode decoder.
  Assumes one AHB-Lite master (this bench) and the issue stage model.
*/
`timescale 1ns/1ps
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic instr_valid, dec_valid, dec_rsvd, exc_reserved, exc_disabled;
  logic hreadyout, hresp, irq, hsel, hwrite, v_q, en_q, er, cc, fc, ex;
  logic [31:0] instr_word, dec_word, hrdata, haddr, hwdata, rd, w_q, r, w;
  logic [1:0] dec_fmt, htrans, ef;
  logic [2:0] hsize;
  svd_pkg::svd_class_e dec_class, ec;
  svd_pkg::svd_op_e dec_op, eo;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  logic en_exp = 1'b1;

  always #10 hclk = ~hclk;

  svd_issue_model issue (.hclk(hclk), .instr_valid(instr_valid),
    .instr_word(instr_word));
  svd_decoder DUT (.hclk(hclk), .hresetn(hresetn),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .dec_valid(dec_valid), .dec_word(dec_word), .dec_class(dec_class),
    .dec_op(dec_op), .dec_fmt(dec_fmt), .dec_rsvd(dec_rsvd),
    .exc_reserved(exc_reserved), .exc_disabled(exc_disabled),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));

  task automatic stop_test();
    if (bad_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check

  task automatic ahb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
    hsel <= 1'b0;
  endtask : ahb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, rd);
    check(rd, e);
  endtask : rd_chk

  // Reference decode; cc and fc say whether class and format are defined
  function automatic void exp_dec(input logic [31:0] w,
    output svd_pkg::svd_class_e c, output svd_pkg::svd_op_e o,
    output logic [1:0] f, output logic r, output logic cc,
    output logic fc, output logic x);
    svd_pkg::svd_op_e t[16];
    logic [5:0] m;
    t = '{svd_pkg::OP_ADD_IMM, svd_pkg::OP_SUB_IMM, svd_pkg::OP_S_MAX_IMM,
      svd_pkg::OP_U_MAX_IMM, svd_pkg::OP_S_MIN_IMM, svd_pkg::OP_U_MIN_IMM,
      svd_pkg::OP_NONE, svd_pkg::OP_NONE, svd_pkg::OP_CMP_EQ_IMM,
      svd_pkg::OP_NONE, svd_pkg::OP_S_LT_IMM, svd_pkg::OP_U_LT_IMM,
      svd_pkg::OP_S_LE_IMM, svd_pkg::OP_U_LE_IMM, svd_pkg::OP_LOAD_IMM,
      svd_pkg::OP_NONE};
    m = w[5:0];
    c = svd_pkg::CLS_NONE;
    o = svd_pkg::OP_NONE;
    f = w[22:21];
    r = 1'b0;
    cc = 1'b1;
    fc = 1'b0;
    x = 1'b0;
    if (w[31:26] == 6'h11) begin
      c = svd_pkg::CLS_FP;
      if (w[25:21] == 5'h0b) o = svd_pkg::OP_BR_VEC_ALL_ZERO;
      if (w[25:21] == 5'h0f) o = svd_pkg::OP_BR_VEC_NOT_ZERO;
      if (w[25:24] == 2'h3) begin
        o = w[23] ? svd_pkg::OP_BR_NO_ELEM_ZERO : svd_pkg::OP_BR_ANY_ELEM_ZERO;
        fc = 1'b1;
      end
      x = (o != svd_pkg::OP_NONE);
    end else if (w[31:26] == 6'h1e) begin
      x = 1'b1;
      fc = 1'b1;
      if (m[5:3] == 3'h4) begin
        c = svd_pkg::CLS_MEM_OFS;
        o = m[2] ? svd_pkg::OP_VEC_STORE : svd_pkg::OP_VEC_LOAD;
        f = m[1:0];
      end else if (m[5:1] == 5'h03) begin
        c = svd_pkg::CLS_IMM5;
        o = t[{m[0], w[25:23]}];
        r = (o == svd_pkg::OP_NONE);
        cc = !r;
      end else begin
        fc = 1'b0;
        case (m) inside
          [6'h00:6'h02]: c = svd_pkg::CLS_IMM8;
          6'h09, 6'h0a: c = svd_pkg::CLS_BIT;
          [6'h0d:6'h15]: c = svd_pkg::CLS_THREE_REG;
          6'h19: c = svd_pkg::CLS_ELEMENT;
          [6'h1a:6'h1c]: c = svd_pkg::CLS_THREE_REG_FLOAT;
          6'h1e: c = svd_pkg::CLS_VEC_TWO_REG;
          default: c = svd_pkg::CLS_RESERVED;
        endcase
        r = (c == svd_pkg::CLS_RESERVED);
      end
    end
  endfunction : exp_dec

  always @(posedge hclk) begin
    v_q <= instr_valid;
    w_q <= instr_word;
    en_q <= en_exp;
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count++;
      stop_test();
    end
  end

  // Outputs of one edge are compared half a cycle later, once settled
  always @(negedge hclk) begin
    if (hresetn === 1'b1) begin
      exp_dec(w_q, ec, eo, ef, er, cc, fc, ex);
      check(dec_valid, v_q);
      check(exc_reserved, v_q & er & en_q);
      check(exc_disabled, v_q & ex & ~en_q);
      if (v_q) begin
        check(dec_word, w_q);
        check(dec_rsvd, er);
        if (cc) check(dec_class, ec);
        if (cc) check(dec_op, eo);
        if (fc) check(dec_fmt, ef);
      end
    end
  end

  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    v_q = 1'b0;
    void'($urandom(12306));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(8'h00, 32'h1);
    rd_chk(8'h08, 32'h0);
    rd_chk(8'h04, 32'h0);
    for (int i = 0; i < 64; i++) begin
      r = $urandom();
      issue.send({6'h1e, r[19:0], i[5:0]}, 0);
    end
    for (int i = 0; i < 16; i++) begin
      r = $urandom();
      issue.send({6'h1e, i[2:0], r[16:0], 5'h03, i[3]}, 0);
    end
    for (int i = 0; i < 32; i++) begin
      r = $urandom();
      issue.send({6'h11, i[4:0], r[20:0]}, 0);
    end
    issue.send(32'h0, 2);
    rd_chk(8'h04, 32'h5);
    ahb(1'b1, 8'h04, 32'h7, rd);
    rd_chk(8'h04, 32'h0);
    ahb(1'b1, 8'h08, 32'h1, rd);
    rd_chk(8'h08, 32'h1);
    check(irq, 1'b0);
    issue.send(32'h7800003f, 2);
    rd_chk(8'h04, 32'h1);
    check(irq, 1'b1);
    ahb(1'b1, 8'h04, 32'h1, rd);
    @(negedge hclk);
    check(irq, 1'b0);
    ahb(1'b1, 8'h00, 32'h0, rd);
    en_exp = 1'b0;
    rd_chk(8'h00, 32'h0);
    issue.send(32'h7800003f, 0);
    issue.send(32'h45600000, 2);
    ahb(1'b0, 8'h04, 32'h0, rd);
    check(rd & 32'h3, 32'h2);
    ahb(1'b1, 8'h08, 32'h2, rd);
    @(negedge hclk);
    check(irq, 1'b1);
    ahb(1'b1, 8'h08, 32'h0, rd);
    @(negedge hclk);
    check(irq, 1'b0);
    ahb(1'b1, 8'h10, 32'hffffffff, rd);
    rd_chk(8'h10, 32'h0);
    rd_chk(8'h0c, 32'h45600000);
    ahb(1'b1, 8'h00, 32'h1, rd);
    en_exp = 1'b1;
    for (int i = 0; i < 400; i++) begin
      r = $urandom();
      w = r;
      if (r[31]) w[31:26] = r[30] ? 6'h1e : 6'h11;
      issue.send(w, int'(r[29] & r[28]));
    end
    issue.send(32'h0, 2);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(8'h0c, 32'h0);
    rd_chk(8'h04, 32'h0);
    rd_chk(8'h00, 32'h1);
    stop_test();
  end
endmodule : tb
